// file: design/pbsr_top.sv
// Pipelined burst SRAM port: registered command pipeline, byte writes, burst counter, array
// Behaviour
// - Capture all synchronous inputs on rising edge
// - Read data leaves through output registers
// - Deasserted clock qualifier freezes all state except the sleep flag and test port
// - Any read/write mix back to back
// - One data word per cycle when pipeline full
// - Write only lanes with asserted byte select
// - Array write self-timed on the clock
// - Selected only when all chip selects active
// - Output enable gates drivers asynchronously
// - Drivers off during write data phase
// - Output turnaround timed internally
// - Linear or interleaved burst address order
// - Sleep input; tolerates stopped clock
// - Zero wait states at full rate
// - Boundary-scan test access port
// - Array organisation chosen by parameters
`timescale 1ns/10ps
`include "pbsr_defines.svh"
module pbsr_top import pbsr_pkg::*; #(
  parameter int ADDR_W = `PBSR_ADDR_W_DEF,
  parameter int LANES = `PBSR_LANES_DEF,
  parameter int LANE_W = `PBSR_LANE_W_DEF,
  parameter logic [`PBSR_ID_W-1:0] ID_CODE = `PBSR_IDCODE_DEF
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Clock qualifier, burst order strap and sleep
  input wire logic clock_qualifier_n,
  input wire logic burst_order_linear,
  input wire logic sleep_request,
  output logic sleep_active,
  // Command
  input wire logic [ADDR_W-1:0] addr,
  input wire logic write_enable_n,
  input wire logic [LANES-1:0] byte_lane_write_select_n,
  input wire logic chip_select_first_n,
  input wire logic chip_select_second,
  input wire logic chip_select_third_n,
  input wire logic burst_advance_or_load,
  input wire logic output_enable_n,
  // Data pins
  input wire logic [LANES*LANE_W-1:0] dq_in,
  output logic [LANES*LANE_W-1:0] dq_out,
  output logic dq_oe_n,
  // Test pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe_n
);
  localparam int DATA_W = LANES * LANE_W;

  // Whole pipeline state
  typedef struct packed {
    logic [ADDR_W-1:0] burst_base;
    logic [`PBSR_BURST_W-1:0] burst_cnt;
    logic burst_sel;
    logic burst_wr;
    logic burst_linear;
    logic s1_vld;
    logic s1_wr;
    logic [ADDR_W-1:0] s1_addr;
    logic [LANES-1:0] s1_be;
    logic s2_vld;
    logic s2_wr;
    logic [ADDR_W-1:0] s2_addr;
    logic [LANES-1:0] s2_be;
    logic [DATA_W-1:0] dout;
    logic drive_n;
    logic asleep;
  } pbsr_core_t;

  pbsr_core_t st_r;
  pbsr_core_t st_nxt;
  logic [DATA_W-1:0] mem [0:(2**ADDR_W)-1];
  logic [DATA_W-1:0] rd_word;
  logic selected;
  logic [`PBSR_BURST_W-1:0] cnt_step;
  pbsr_tap_if tp ();

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Replace the enabled byte lanes of a word
  function automatic logic [DATA_W-1:0] pbsr_merge(input logic [DATA_W-1:0] old_w,
                                                   input logic [DATA_W-1:0] new_w,
                                                   input logic [LANES-1:0] be);
    pbsr_merge = old_w;
    for (int i = 0; i < LANES; i++) begin
      if (be[i]) begin
        pbsr_merge[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
      end
    end
  endfunction : pbsr_merge

  // Burst address from base and counter
  function automatic logic [ADDR_W-1:0] pbsr_burst_addr(input logic [ADDR_W-1:0] base,
                                                        input logic [`PBSR_BURST_W-1:0] cnt,
                                                        input logic linear);
    pbsr_burst_addr = base;
    if (linear) begin
      pbsr_burst_addr[`PBSR_BURST_W-1:0] = base[`PBSR_BURST_W-1:0] + cnt;
    end else begin
      pbsr_burst_addr[`PBSR_BURST_W-1:0] = base[`PBSR_BURST_W-1:0] ^ cnt;
    end
  endfunction : pbsr_burst_addr

  ////////////////////////////////////////////////////////////////////////////////
  // Command decode

  // All three chip selects must be active, and no sleep pending
  assign selected = !chip_select_first_n && chip_select_second && !chip_select_third_n
                    && !sleep_request;
  assign cnt_step = st_r.burst_cnt + `PBSR_BURST_STEP;

  // Read word with forwarding of the write that commits on this same edge
  always_comb begin
    rd_word = mem[st_r.s1_addr];
    if (st_r.s2_vld && st_r.s2_wr && st_r.s2_addr == st_r.s1_addr) begin
      rd_word = pbsr_merge(rd_word, dq_in, st_r.s2_be);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_nxt = st_r;
    // Sleep flag shows once the pipeline has drained
    st_nxt.asleep = sleep_request && !st_r.s1_vld && !st_r.s2_vld;
    if (!clock_qualifier_n) begin
      // Input register stage, one command every edge
      if (!burst_advance_or_load) begin
        st_nxt.burst_base = addr;
        st_nxt.burst_cnt = `PBSR_BURST_START;
        st_nxt.burst_sel = selected;
        st_nxt.burst_wr = !write_enable_n;
        st_nxt.burst_linear = burst_order_linear;
        st_nxt.s1_vld = selected;
        st_nxt.s1_wr = !write_enable_n;
        st_nxt.s1_addr = addr;
      end else begin
        st_nxt.burst_cnt = cnt_step;
        st_nxt.s1_vld = st_r.burst_sel && !sleep_request;
        st_nxt.s1_wr = st_r.burst_wr;
        st_nxt.s1_addr = pbsr_burst_addr(st_r.burst_base, cnt_step, st_r.burst_linear);
      end
      st_nxt.s1_be = ~byte_lane_write_select_n;
      // Second stage holds the write while its data is on the bus
      st_nxt.s2_vld = st_r.s1_vld;
      st_nxt.s2_wr = st_r.s1_wr;
      st_nxt.s2_addr = st_r.s1_addr;
      st_nxt.s2_be = st_r.s1_be;
      // Output register loads read data one edge before the host samples it
      if (st_r.s1_vld && !st_r.s1_wr) begin
        st_nxt.dout = rd_word;
      end
      // Drive only during a read data phase, released for write data
      st_nxt.drive_n = !(st_r.s1_vld && !st_r.s1_wr);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  // Pipeline register
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_r <= '0;
      st_r.drive_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Self-timed array write of the second stage, lanes masked
  always_ff @(posedge mclk) begin
    if (!clock_qualifier_n && st_r.s2_vld && st_r.s2_wr) begin
      mem[st_r.s2_addr] <= pbsr_merge(mem[st_r.s2_addr], dq_in, st_r.s2_be);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs and test port

  assign dq_out = st_r.dout;
  assign dq_oe_n = st_r.drive_n || output_enable_n;
  assign sleep_active = st_r.asleep;

  // Test pins travel to the access port
  assign tp.tck = tck;
  assign tp.tms = tms;
  assign tp.tdi = tdi;
  assign tdo = tp.tdo;
  assign tdo_oe_n = tp.tdo_oe_n;

  pbsr_tap #(
    .ID_CODE(ID_CODE)
  ) u_tap (
    .mclk(mclk),
    .reset(reset),
    .tp(tp.tap)
  );
endmodule : pbsr_top

// file: design/pbsr_defines.svh
// Constants of the pipelined burst SRAM port
`ifndef PBSR_DEFINES_SVH
`define PBSR_DEFINES_SVH
// Array organisation defaults (2M words of four 9-bit lanes)
`define PBSR_ADDR_W_DEF 21
`define PBSR_LANES_DEF 4
`define PBSR_LANE_W_DEF 9
// Burst counter
`define PBSR_BURST_W 2
`define PBSR_BURST_START 2'h0
`define PBSR_BURST_STEP 2'h1
// Test port identity code, arbitrary value
`define PBSR_IDCODE_DEF 32'h1234_5671
// Test port instruction register
`define PBSR_IR_W 2
`define PBSR_IR_CAPTURE 2'h1
`define PBSR_IR_IDCODE 2'h1
`define PBSR_IR_BYPASS 2'h3
`define PBSR_ID_W 32
`endif

// file: design/pbsr_pkg.sv
// Types shared by the SRAM port and its test access port
package pbsr_pkg;
  // Test access port controller states
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PAU_DR, TAP_EX2_DR,
    TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
  } pbsr_tap_state_t;
endpackage : pbsr_pkg

// file: design/pbsr_tap_if.sv
// Carrier between the SRAM core and its test access port
`timescale 1ns/10ps
interface pbsr_tap_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_oe_n;
  modport core (output tck, output tms, output tdi, input tdo, input tdo_oe_n);
  modport tap (input tck, input tms, input tdi, output tdo, output tdo_oe_n);
endinterface : pbsr_tap_if

// file: design/pbsr_tap.sv
// Boundary-scan test access port with bypass and identity registers
`timescale 1ns/10ps
`include "pbsr_defines.svh"
module pbsr_tap import pbsr_pkg::*; #(
  parameter logic [`PBSR_ID_W-1:0] ID_CODE = `PBSR_IDCODE_DEF
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Test pins
  pbsr_tap_if.tap tp
);
  typedef struct packed {
    logic tck_q;
    pbsr_tap_state_t state;
    logic [`PBSR_IR_W-1:0] ir;
    logic [`PBSR_IR_W-1:0] ir_sh;
    logic [`PBSR_ID_W-1:0] dr_sh;
    logic tdo;
    logic tdo_oe_n;
  } pbsr_tap_st_t;

  pbsr_tap_st_t st_r;
  pbsr_tap_st_t st_nxt;
  logic tck_rise;
  logic tck_fall;

  // Controller state graph
  function automatic pbsr_tap_state_t pbsr_tap_next(input pbsr_tap_state_t s, input logic tms);
    case (s)
      TAP_RESET: pbsr_tap_next = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: pbsr_tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: pbsr_tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR, TAP_SH_DR: pbsr_tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: pbsr_tap_next = tms ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: pbsr_tap_next = tms ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: pbsr_tap_next = tms ? TAP_UPD_DR : TAP_SH_DR;
      TAP_SEL_IR: pbsr_tap_next = tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR, TAP_SH_IR: pbsr_tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: pbsr_tap_next = tms ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: pbsr_tap_next = tms ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: pbsr_tap_next = tms ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_DR, TAP_UPD_IR: pbsr_tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      default: pbsr_tap_next = TAP_RESET;
    endcase
  endfunction : pbsr_tap_next

  // Test clock is a synchronous input; edges found against mclk
  assign tck_rise = tp.tck && !st_r.tck_q;
  assign tck_fall = !tp.tck && st_r.tck_q;

  // Shift, capture and update on test clock edges
  always_comb begin
    st_nxt = st_r;
    st_nxt.tck_q = tp.tck;
    if (tck_rise) begin
      st_nxt.state = pbsr_tap_next(st_r.state, tp.tms);
      case (st_r.state)
        TAP_RESET: st_nxt.ir = `PBSR_IR_IDCODE;
        TAP_CAP_IR: st_nxt.ir_sh = `PBSR_IR_CAPTURE;
        TAP_SH_IR: st_nxt.ir_sh = {tp.tdi, st_r.ir_sh[`PBSR_IR_W-1:1]};
        TAP_UPD_IR: st_nxt.ir = st_r.ir_sh;
        TAP_CAP_DR: st_nxt.dr_sh = (st_r.ir == `PBSR_IR_IDCODE) ? ID_CODE : '0;
        TAP_SH_DR: begin
          if (st_r.ir == `PBSR_IR_IDCODE) begin
            st_nxt.dr_sh = {tp.tdi, st_r.dr_sh[`PBSR_ID_W-1:1]};
          end else begin
            st_nxt.dr_sh[0] = tp.tdi; // Single-bit bypass
          end
        end
        default: st_nxt.ir = st_r.ir;
      endcase
    end
    if (tck_fall) begin
      st_nxt.tdo_oe_n = !(st_r.state == TAP_SH_DR || st_r.state == TAP_SH_IR);
      st_nxt.tdo = (st_r.state == TAP_SH_IR) ? st_r.ir_sh[0] : st_r.dr_sh[0];
    end
  end

  // State register
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_r <= '{tck_q: 1'b0, state: TAP_RESET, ir: `PBSR_IR_IDCODE, ir_sh: '0, dr_sh: '0,
                tdo: 1'b0, tdo_oe_n: 1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tp.tdo = st_r.tdo;
  assign tp.tdo_oe_n = st_r.tdo_oe_n;
endmodule : pbsr_tap

// file: dv/pbsr_host_model.sv
// Host side write data driver for the SRAM data pins
`timescale 1ns/10ps
module pbsr_host_model (
  // Clock
  input wire logic mclk,
  // Write data request
  input wire logic drive,
  input wire logic [35:0] wdata,
  // Data pins toward the port
  output logic [35:0] dq_in
);
  logic [35:0] last_r = 36'h0_0000_0000;
  // Remember what stood on the bus last cycle
  always @(posedge mclk) begin
    last_r <= dq_in;
  end
  // Released bus shows the inverse of the last value, never a stale copy
  assign dq_in = drive ? wdata : ~last_r;
endmodule : pbsr_host_model

// file: dv/pbsr_chk_sva.sv
// Pin level assertions for the SRAM port
`timescale 1ns/10ps
module pbsr_chk_sva #(parameter int LANES = 4, parameter int LANE_W = 9) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Control inputs
  input wire logic clock_qualifier_n,
  input wire logic sleep_request,
  input wire logic write_enable_n,
  input wire logic chip_select_first_n,
  input wire logic chip_select_second,
  input wire logic chip_select_third_n,
  input wire logic burst_advance_or_load,
  input wire logic output_enable_n,
  // Outputs
  input wire logic sleep_active,
  input wire logic [LANES*LANE_W-1:0] dq_out,
  input wire logic dq_oe_n
);
  logic cs_ok;
  logic ld;
  logic op;
  // All three selects active, and a load on an edge the port really takes (out of reset)
  assign cs_ok = !chip_select_first_n && chip_select_second && !chip_select_third_n;
  assign ld = !burst_advance_or_load && !clock_qualifier_n && !reset;
  assign op = ld && cs_ok && !sleep_request;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  oe_gate_a: assert property (output_enable_n |-> dq_oe_n) else $error("drive with enable off");
  write_hiz_a: assert property (op && !write_enable_n ##1 !clock_qualifier_n |=> dq_oe_n)
    else $error("drive in write phase");
  read_drive_a: assert property (op && write_enable_n ##1 !clock_qualifier_n
    |=> output_enable_n || !dq_oe_n) else $error("read not driven");
  freeze_out_a: assert property (clock_qualifier_n |=> $stable(dq_out)) else $error("data moved while held");
  freeze_drive_a: assert property (clock_qualifier_n ##1 $stable(output_enable_n) |-> $stable(dq_oe_n))
    else $error("drive moved while held");
  deselect_a: assert property (ld && !cs_ok ##1 !clock_qualifier_n |=> dq_oe_n)
    else $error("drive after deselect");
  sleep_off_a: assert property (!sleep_request |=> !sleep_active) else $error("sleep flag without request");
  sleep_on_a: assert property ((sleep_request && !clock_qualifier_n) [*4] |=> sleep_active)
    else $error("sleep flag missing");
endmodule : pbsr_chk_sva
bind pbsr_top pbsr_chk_sva #(.LANES(LANES), .LANE_W(LANE_W)) u_chk (.mclk, .reset, .clock_qualifier_n, .sleep_request,
  .write_enable_n, .chip_select_first_n, .chip_select_second, .chip_select_third_n, .burst_advance_or_load,
  .output_enable_n, .sleep_active, .dq_out, .dq_oe_n);

// file: dv/tb.sv
// Self-checking bench for the pipelined burst SRAM port
`timescale 1ns/10ps
`include "pbsr_defines.svh"
module tb;
  typedef struct packed {logic v; logic wr; logic [3:0] a; logic [3:0] ben; logic [35:0] d;} pbsr_op_t;
  logic mclk = 0, reset = 1, cq_n = 0, lin = 1, slp = 0, we_n = 1, cs1_n = 0, cs2 = 1, cs3_n = 0, adv = 0, oe_n = 0;
  logic [20:0] addr = 21'h00_0000;
  logic [3:0] ben = 4'hf;
  logic [35:0] dq_in, dq_out, mem [16];
  logic dq_oe_n, slp_act;
  logic tck = 0, tms = 1, tdi = 0, tdo, tdo_oe_n;
  logic [3:0] base;
  logic [1:0] cnt;
  pbsr_op_t iss = '0, p1 = '0, p2 = '0, last;
  int err_count = 0, check_count = 0;
  ////////////////////////////////////////////////////////////////////////
  // Clock, design and host
  always #10 mclk = ~mclk;
  pbsr_top DUT (.mclk(mclk), .reset(reset), .clock_qualifier_n(cq_n), .burst_order_linear(lin), .sleep_request(slp),
    .sleep_active(slp_act), .addr(addr), .write_enable_n(we_n), .byte_lane_write_select_n(ben),
    .chip_select_first_n(cs1_n), .chip_select_second(cs2), .chip_select_third_n(cs3_n), .burst_advance_or_load(adv),
    .output_enable_n(oe_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe_n(tdo_oe_n));
  pbsr_host_model HOST (.mclk(mclk), .drive(p2.v && p2.wr), .wdata(p2.d), .dq_in(dq_in));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [35:0] s, input logic [35:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  // Shadow pipeline: commits writes, judges reads two enabled edges after issue
  always @(posedge mclk) begin
    if (!reset && !cq_n) begin
      if (p2.v && p2.wr) begin
        for (int i = 0; i < 4; i++) if (!p2.ben[i]) mem[p2.a][i*9+:9] = p2.d[i*9+:9];
      end else if (p2.v) begin
        chk("dq_out", dq_out, mem[p2.a]);
        chk("dq_oe_n", dq_oe_n, oe_n);
      end
      p2 <= p1;
      p1 <= iss;
    end
  end
  // One command a cycle; advances follow the burst order of the last load
  task automatic cmd(input logic ad, wr, input logic [3:0] a, be, input logic [35:0] d, input logic [2:0] s);
    @(posedge mclk);
    if (!ad) begin
      base = a;
      cnt = 0;
      last = '{(s == 3'b010) && !slp, wr, a, be, d};
    end else begin
      cnt++;
      last.a = {base[3:2], lin ? base[1:0] + cnt : base[1:0] ^ cnt};
      last.ben = be;
      last.d = d;
    end
    adv <= ad;
    we_n <= !wr;
    addr <= {17'h0_0000, a};
    ben <= be;
    {cs1_n, cs2, cs3_n} <= s;
    iss <= last;
  endtask : cmd
  task automatic drain;
    repeat (3) cmd(0, 0, 0, 4'hf, 0, 3'b000);
  endtask : drain
  ////////////////////////////////////////////////////////////////////////
  task automatic t_b2b;
    for (int i = 0; i < 16; i++) cmd(0, 1, i, 4'h0, 36'h9_A5C3_0F00 + i, 3'b010);
    for (int i = 0; i < 16; i++) cmd(0, !i[0], i[4:1], 4'h0, 36'h0_BEEF_0000 + i, 3'b010);
    for (int i = 0; i < 4; i++) begin
      cmd(0, 1, 3, 4'(i * 5), 36'h5_5555_5555 ^ i, 3'b010);
      cmd(0, 0, 3, 4'hf, 0, 3'b010);
    end
    drain;
  endtask : t_b2b
  task automatic t_burst;
    for (int o = 0; o < 2; o++) begin
      lin <= o[0];
      for (int k = 0; k < 4; k++) cmd(k != 0, 1, 4'h5, 4'h0, 36'h0_0C0D_E000 + 16 * o + k, 3'b010);
      for (int k = 0; k < 4; k++) cmd(0, 0, 4'h4 + k, 4'h0, 0, 3'b010);
    end
    drain;
  endtask : t_burst
  task automatic t_stall;
    cmd(0, 0, 2, 4'hf, 0, 3'b010);
    cmd(0, 0, 0, 4'hf, 0, 3'b000);
    cmd(0, 0, 0, 4'hf, 0, 3'b000);
    cq_n <= 1;
    repeat (4) @(posedge mclk);
    chk("held drive", dq_oe_n, 0);
    cq_n <= 0;
    drain;
  endtask : t_stall
  task automatic t_gate;
    oe_n <= 1;
    cmd(0, 0, 1, 4'hf, 0, 3'b010);
    cmd(0, 0, 2, 4'hf, 0, 3'b010);
    drain;
    oe_n <= 0;
    for (int s = 0; s < 3; s++) cmd(0, 1, 1, 4'h0, 36'hF_0000_000F, 3'b010 ^ (3'b100 >> s));
    cmd(0, 0, 1, 4'hf, 0, 3'b010);
    drain;
  endtask : t_gate
  task automatic t_sleep;
    slp <= 1;
    cmd(0, 1, 2, 4'h0, 36'h1_1111_1111, 3'b010);
    repeat (5) cmd(0, 0, 0, 4'hf, 0, 3'b000);
    #1 chk("sleep_active", slp_act, 1);
    @(posedge mclk);
    slp <= 0;
    drain;
    #1 chk("sleep_active", slp_act, 0);
    cmd(0, 0, 2, 4'hf, 0, 3'b010);
    drain;
  endtask : t_sleep
  // One test clock period: rise seen one edge later, fall two edges after that
  task automatic tcyc(input logic m);
    @(posedge mclk);
    tms <= m;
    tck <= 1;
    repeat (2) @(posedge mclk);
    tck <= 0;
    repeat (2) @(posedge mclk);
  endtask : tcyc
  // Identity register shifts out LSB first from the test port reset state
  task automatic t_tap;
    logic [31:0] id;
    tcyc(0);
    tcyc(1);
    tcyc(0);
    tcyc(0);
    for (int i = 0; i < 32; i++) begin
      id[i] = tdo;
      chk("tdo_oe_n", tdo_oe_n, 0);
      tcyc(i == 31);
    end
    chk("idcode", id, `PBSR_IDCODE_DEF);
    chk("tdo_oe_n", tdo_oe_n, 1);
  endtask : t_tap
  ////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    if (err_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  // Watchdog far beyond the few hundred cycles the tests need
  initial begin
    #100us;
    err_count++;
    end_of_test;
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge mclk);
    reset <= 0;
    t_b2b;
    t_burst;
    t_stall;
    t_gate;
    t_sleep;
    t_tap;
    end_of_test;
  end
endmodule : tb
